// File: rtl/mtc_pkg.sv
package mtc_pkg;

	// ****************************************************************
	// register map (byte addresses, one aligned word each)
	// ****************************************************************
	localparam logic [11:0] MTC_CTRL_OFS   = 12'h000;
	localparam logic [11:0] MTC_CMD_OFS    = 12'h004;
	localparam logic [11:0] MTC_STATUS_OFS = 12'h008;
	localparam logic [11:0] MTC_COUNT_OFS  = 12'h00c;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CTRL_SRC_EXT_BIT = 0; // 1: external_event_source, 0: internal
	localparam int CTRL_CONT_BIT    = 1; // continuous_run_command state
	localparam int CTRL_EDGE_BIT    = 2; // trigger_edge_select, 1: release edge
	localparam int CTRL_W           = 3;
	localparam int CMD_EXTERNAL_TRIGGER_INPUT_BIT     = 0; // remote_trigger_command
	localparam int ST_BUSY_BIT      = 0;
	localparam int ST_PEND_BIT      = 1;
	localparam int ST_DELAY_BIT     = 2;
	localparam int ST_LEVEL_BIT     = 3;

	// internal source, continuous on, assert edge
	localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h2;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_MHZ          = 100;
	localparam int REL_EXTRA_US     = 1000; // 1.0 ms added on the release edge
	localparam int REL_DELAY_CYC_DF = REL_EXTRA_US * CLK_MHZ;

	typedef enum logic [1:0] {
		MTC_IDLE  = 2'b00,
		MTC_DELAY = 2'b01,
		MTC_RUN   = 2'b10
	} mtc_state_t;

endpackage

// File: rtl/mtc_trigger_ctrl.sv
// Operation
// - internal source with continuous on: start measurements back to back, free-running
// - internal source with continuous on: ignore external input and remote command
// - external source: one measurement started per accepted external edge
// - continuous off: only controller triggers (remote command or pin) start measurements
// - edge select chooses assert or release transition as the trigger event
// - release-edge trigger adds a 1.0 ms delay before measurement start
// - trigger during a measurement is latched once and serviced afterwards
`timescale 1ns/1ps
module mtc_trigger_ctrl
	import mtc_pkg::*;
#(
	parameter int unsigned REL_DELAY_CYC = REL_DELAY_CYC_DF
) (
	input  wire logic        pclk,       // 100 MHz clock
	input  wire logic        presetn,    // async reset, active low
	input  wire logic        psel,       // apb select
	input  wire logic        penable,    // apb access phase
	input  wire logic        pwrite,     // apb direction
	input  wire logic [11:0] paddr,      // apb byte address
	input  wire logic [31:0] pwdata,     // apb write data
	output logic      [31:0] prdata,     // apb read data
	output logic             pready,     // apb ready
	output logic             pslverr,    // apb error, unmapped address
	input  wire logic        ext_external_trigger_input_in,// external_trigger_input, high = asserted
	input  wire logic        meas_done,  // measurement engine finished, pulse
	output logic             meas_start, // one-cycle start pulse
	output logic             meas_busy   // measurement delayed or running
);

	// ****************************************************************
	// apb slave
	// ****************************************************************
	localparam int CW = $clog2(REL_DELAY_CYC + 1);

	logic [CTRL_W-1:0] ctrl_q;
	logic              cmd_pulse_q;
	logic [31:0]       count_q;
	logic              pend_q;
	logic              pend_ext_q;
	logic              lvl_q;
	mtc_state_t        state_q;
	logic              acc;
	logic              wr_fire;
	logic              mapped;

	assign acc     = psel && penable;
	assign wr_fire = acc && pready && pwrite;
	assign mapped  = (paddr == MTC_CTRL_OFS) || (paddr == MTC_CMD_OFS) ||
	                 (paddr == MTC_STATUS_OFS) || (paddr == MTC_COUNT_OFS);

	// one wait state keeps read data registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= acc && !pready;
			pslverr <= acc && !pready && !mapped;
			prdata  <= 32'h0;
			if (acc && !pready && !pwrite) begin
				case (paddr)
				MTC_CTRL_OFS:   prdata <= {{(32-CTRL_W){1'b0}}, ctrl_q};
				MTC_STATUS_OFS: begin
					prdata[ST_BUSY_BIT]  <= state_q != MTC_IDLE;
					prdata[ST_PEND_BIT]  <= pend_q;
					prdata[ST_DELAY_BIT] <= state_q == MTC_DELAY;
					prdata[ST_LEVEL_BIT] <= lvl_q;
				end
				MTC_COUNT_OFS:  prdata <= count_q;
				default:        prdata <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr_fire && paddr == MTC_CTRL_OFS) begin
			ctrl_q <= pwdata[CTRL_W-1:0];
		end
	end

	// the command register is write-only; a write with bit 0 set strobes the remote trigger
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_pulse_q <= 1'b0;
		end else begin
			cmd_pulse_q <= wr_fire && paddr == MTC_CMD_OFS && pwdata[CMD_EXTERNAL_TRIGGER_INPUT_BIT];
		end
	end

	// ****************************************************************
	// external input synchroniser and edge detect
	// ****************************************************************
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic rise;
	logic fall;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			lvl_q <= 1'b0;
		end else begin
			s1_q <= ext_external_trigger_input_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				lvl_q <= s3_q;
			end
		end
	end

	assign rise = (s2_q == s3_q) && s3_q && !lvl_q;
	assign fall = (s2_q == s3_q) && !s3_q && lvl_q;

	// ****************************************************************
	// trigger qualification
	// ****************************************************************
	logic src_ext;
	logic cont;
	logic edge_rel;
	logic freerun;
	logic ext_ev;
	logic cmd_ev;
	logic ev;

	assign src_ext  = ctrl_q[CTRL_SRC_EXT_BIT];
	assign cont     = ctrl_q[CTRL_CONT_BIT];
	assign edge_rel = ctrl_q[CTRL_EDGE_BIT];
	assign freerun  = !src_ext && cont;
	// free-run locks out every outside trigger
	assign ext_ev   = !freerun && (edge_rel ? fall : rise);
	assign cmd_ev   = !freerun && cmd_pulse_q;
	assign ev       = ext_ev || cmd_ev;

	// ****************************************************************
	// measurement sequencer
	// ****************************************************************
	logic [CW-1:0] dly_q;
	logic          go;
	logic          go_ext;

	always_comb begin
		go     = 1'b0;
		go_ext = 1'b0;
		if (state_q == MTC_IDLE) begin
			if (pend_q) begin
				go     = 1'b1;
				go_ext = pend_ext_q;
			end else if (ev) begin
				go     = 1'b1;
				go_ext = ext_ev;
			end else if (freerun) begin
				go     = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= MTC_IDLE;
			dly_q      <= '0;
			meas_start <= 1'b0;
		end else begin
			meas_start <= 1'b0;
			case (state_q)
			MTC_IDLE: begin
				if (go && go_ext && edge_rel) begin
					state_q <= MTC_DELAY;
					dly_q   <= '0;
				end else if (go) begin
					state_q    <= MTC_RUN;
					meas_start <= 1'b1;
				end
			end
			MTC_DELAY: begin
				dly_q <= dly_q + 1'b1;
				if (dly_q == CW'(REL_DELAY_CYC - 1)) begin
					state_q    <= MTC_RUN;
					meas_start <= 1'b1;
				end
			end
			MTC_RUN: begin
				if (meas_done) begin
					state_q <= MTC_IDLE;
				end
			end
			default: state_q <= MTC_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meas_busy <= 1'b0;
		end else begin
			meas_busy <= (state_q == MTC_IDLE) ? go : !(state_q == MTC_RUN && meas_done);
		end
	end

	// a new event in the consuming cycle is kept: set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q     <= 1'b0;
			pend_ext_q <= 1'b0;
		end else if (ev && (state_q != MTC_IDLE || pend_q)) begin
			pend_q <= 1'b1;
			if (!pend_q || (state_q == MTC_IDLE)) begin
				pend_ext_q <= ext_ev;
			end
		end else if (state_q == MTC_IDLE && pend_q) begin
			pend_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= 32'h0;
		end else if (meas_start) begin
			count_q <= count_q + 32'h1;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	a_freerun_restart: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == MTC_IDLE && freerun |=> meas_start)
		else $error("free-run did not restart");
	a_internal_ignores: assert property (@(posedge pclk) disable iff (!presetn)
		freerun |-> !ext_ev && !cmd_ev)
		else $error("trigger accepted in free-run");
	a_ext_one_start: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == MTC_IDLE && !pend_q && ext_ev && !edge_rel |=> meas_start ##1 !meas_start)
		else $error("external edge did not give one start");
	a_noncont_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == MTC_IDLE && !pend_q && !ev && !cont |=> !meas_start)
		else $error("start without controller trigger");
	a_edge_polarity: assert property (@(posedge pclk) disable iff (!presetn)
		ext_ev |-> (edge_rel ? $fell(lvl_q) == 1'b0 && lvl_q : !lvl_q))
		else $error("wrong trigger edge");
	a_rel_delay_len: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(state_q == MTC_DELAY) |-> !meas_start [*2])
		else $error("release delay too short");
	a_delay_exit: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == MTC_DELAY && dly_q == CW'(REL_DELAY_CYC - 1) |=> meas_start && state_q == MTC_RUN)
		else $error("release delay did not end");
	a_pend_latch: assert property (@(posedge pclk) disable iff (!presetn)
		ev && state_q == MTC_RUN |=> pend_q)
		else $error("trigger during measurement lost");
	a_pend_served: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == MTC_IDLE && pend_q |=> state_q != MTC_IDLE)
		else $error("pending trigger not served");
	a_sync_single: assert property (@(posedge pclk) disable iff (!presetn)
		rise |=> !rise)
		else $error("edge pulse longer than one cycle");

	c_freerun: cover property (@(posedge pclk) disable iff (!presetn) freerun && meas_start);
	c_rel_start: cover property (@(posedge pclk) disable iff (!presetn)
		state_q == MTC_DELAY ##1 meas_start);
	c_pending: cover property (@(posedge pclk) disable iff (!presetn) pend_q && meas_done);

endmodule

// File: dv/mtc_plc_model.sv
`timescale 1ns/1ps
module mtc_plc_model #(
	parameter int HOLD = 6,
	parameter int RUN  = 40
) (
	input  wire logic pclk,       // instrument clock
	input  wire logic presetn,    // async reset, active low
	input  wire logic fire,       // bench asks for one trigger pulse
	input  wire logic meas_start, // measurement start pulse
	input  wire logic meas_busy,  // measurement in progress
	output logic      external_trigger_input_q,     // external_trigger_input level
	output logic      done_q      // end of measurement pulse
);
	int hold_q;
	int run_q;

	// the controller never triggers into a busy device, so a stray request is dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			external_trigger_input_q <= 1'b0;
			hold_q <= 0;
		end else if (fire && !meas_busy) begin
			external_trigger_input_q <= 1'b1;
			hold_q <= HOLD;
		end else if (hold_q > 1) begin
			hold_q <= hold_q - 1;
		end else if (hold_q == 1) begin
			hold_q <= 0;
			external_trigger_input_q <= 1'b0;
		end
	end

	// measurement engine: fixed run length ends with one done pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q  <= 0;
			done_q <= 1'b0;
		end else begin
			done_q <= (run_q == 1);
			if (meas_start)
				run_q <= RUN;
			else if (run_q > 0)
				run_q <= run_q - 1;
		end
	end
endmodule

// File: dv/measurement_trigger_control_test.sv
`timescale 1ns/1ps
module measurement_trigger_control_test;
	import mtc_pkg::*;
	localparam int HOLD = 6;
	localparam int REL  = 8;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, ext_external_trigger_input_in, meas_done, meas_start, meas_busy, fire = 1'b0;
	logic        er;
	logic [31:0] c0;
	int          err_count = 0, num_checks = 0, starts = 0, cyc = 0, t_fire = 0, lat = 0, la;

	always #5 pclk = ~pclk;

	mtc_trigger_ctrl #(.REL_DELAY_CYC(REL)) u_mtc_trigger_ctrl (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_external_trigger_input_in(ext_external_trigger_input_in),
		.meas_done(meas_done), .meas_start(meas_start), .meas_busy(meas_busy));
	mtc_plc_model #(.HOLD(HOLD), .RUN(40)) u_mtc_plc_model (.pclk(pclk), .presetn(presetn),
		.fire(fire), .meas_start(meas_start), .meas_busy(meas_busy), .external_trigger_input_q(ext_external_trigger_input_in),
		.done_q(meas_done));

	always @(posedge pclk) begin
		cyc++;
		if (meas_start === 1'b1) begin
			starts++;
			lat = cyc - t_fire;
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task pulse_pin();
		t_fire = cyc + 1;
		fire <= 1'b1;
		@(posedge pclk);
		fire <= 1'b0;
	endtask

	task finish_test();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#300000;
		err_count++;
		finish_test();
	end

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, MTC_CTRL_OFS, 32'h0);
		check(rd, 32'h2);
		apb(1'b0, 12'h010, 32'h0);
		check(32'(er), 32'h1);
		check(rd, 32'h0);
		$display("registers done");
		starts = 0;
		repeat (200) @(posedge pclk);
		check(32'(starts >= 3), 32'h1);
		// the model only fires between runs, so aim at the one idle cycle after done
		@(posedge pclk iff meas_done === 1'b1);
		pulse_pin();
		apb(1'b1, MTC_CMD_OFS, 32'h1);
		apb(1'b0, MTC_STATUS_OFS, 32'h0);
		check(32'(rd[ST_PEND_BIT]), 32'h0);
		check(32'(rd[ST_BUSY_BIT]), 32'h1);
		check(32'(rd[ST_LEVEL_BIT]), 32'h1);
		$display("free run done");
		apb(1'b1, MTC_CTRL_OFS, 32'h1);
		repeat (100) @(posedge pclk);
		starts = 0;
		pulse_pin();
		@(posedge pclk iff meas_start === 1'b1);
		check(32'(meas_busy), 32'h1);
		apb(1'b0, MTC_STATUS_OFS, 32'h0);
		check(32'(rd[ST_BUSY_BIT]), 32'h1);
		repeat (100) @(posedge pclk);
		check(starts, 1);
		check(32'(meas_busy), 32'h0);
		la = lat;
		starts = 0;
		apb(1'b1, MTC_CMD_OFS, 32'h1);
		repeat (100) @(posedge pclk);
		check(starts, 1);
		starts = 0;
		apb(1'b1, MTC_CMD_OFS, 32'h1);
		apb(1'b1, MTC_CMD_OFS, 32'h1);
		apb(1'b1, MTC_CMD_OFS, 32'h1);
		repeat (150) @(posedge pclk);
		check(starts, 2);
		$display("controller triggers done");
		apb(1'b1, MTC_CTRL_OFS, 32'h5);
		apb(1'b0, MTC_COUNT_OFS, 32'h0);
		c0 = rd;
		starts = 0;
		pulse_pin();
		@(posedge pclk iff meas_busy === 1'b1);
		apb(1'b0, MTC_STATUS_OFS, 32'h0);
		check(32'(rd[ST_DELAY_BIT]), 32'h1);
		repeat (100) @(posedge pclk);
		check(starts, 1);
		check(lat - la, HOLD + REL);
		apb(1'b0, MTC_COUNT_OFS, 32'h0);
		check(rd - c0, 32'h1);
		$display("release edge done");
		finish_test();
	end
endmodule
